//--- rtl/nfs_pkg.sv
// nfs_pkg: register map, field layout and reset values of the front-end
// status and tuning register bank; shared by the bank and its result latch
package nfs_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_STATUS  = 8'h24;
  localparam logic [7:0] IDX_RESULT  = 8'h25;
  localparam logic [7:0] IDX_TUNE_A  = 8'h26;
  localparam logic [7:0] IDX_TUNE_B  = 8'h27;
  localparam logic [7:0] IDX_DRIVER  = 8'h28;

  // status register field positions
  localparam int RATE_LSB      = 4;
  localparam int GUARD2_BIT    = 3;
  localparam int GPT_BIT       = 2;
  localparam int NORESP_BIT    = 1;
  localparam int MASKRX_BIT    = 0;

  // driver register field positions
  localparam int MOD_LSB       = 4;
  localparam int RES_LSB       = 0;

  // values after reset
  localparam logic [7:0] TUNE_RST   = 8'h80;
  localparam logic [3:0] MOD_RST    = 4'h7;
  localparam logic [3:0] RES_RST    = 4'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // driver resistance code that floats the output
  localparam logic [3:0] RES_HIGHZ  = 4'hF;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/nfs_result_latch.sv
// nfs_result_latch: keeps the last completed converter result
// assumes done is a one-cycle pulse on ref_clk with data valid alongside
`timescale 1ns/1ps
`default_nettype none
module nfs_result_latch #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // converter side
  input  wire logic             convDone,
  input  wire logic [WIDTH-1:0] convData,
  // held value
  output logic      [WIDTH-1:0] result
);

  logic [WIDTH-1:0] result_q;
  logic [WIDTH-1:0] result_d;

  // replaced only on completion
  assign result_d = convDone ? convData : result_q;
  assign result   = result_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      result_q <= WIDTH'(nfs_pkg::RESULT_RST);
    end else begin
      result_q <= result_d;
    end
  end

endmodule
`default_nettype wire

//--- rtl/nfs_regs.sv
// nfs_regs: AXI4-Lite register bank with front-end status and tuning settings
// assumes status, timer and converter inputs come from logic on ref_clk
//
// Notes on behaviour
// - bits 5:4 of the status register show the detected incoming bit rate.
// - bit 3 of the status register is high while the second guard timer counts.
// - bit 2 of the status register is high while the general purpose timer runs.
// - bit 1 of the status register is high while the no-response timer runs.
// - bit 0 of the status register is high while the mask-receive timer runs.
// - the result register holds the last completed conversion until the next one.
// - the first tuning register is read-write, drives converter A, resets to 80h.
// - the second tuning register is read-write, drives converter B, resets to 80h.
// - driver bits 7:4 pick modulation depth 0 to 82 percent, resetting to 7 (15 percent).
// - driver bits 3:0 pick driver resistance, 0 lowest, 15 high impedance, reset 0.
`timescale 1ns/1ps
`default_nettype none
module nfs_regs #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // status from receiver and timers
  input  wire logic [1:0]        detectedRate,
  input  wire logic              second_guard_timer_running,
  input  wire logic              gpTimerRunning,
  input  wire logic              noRespTimerRunning,
  input  wire logic              maskRxTimerRunning,
  // converter result
  input  wire logic              convDone,
  input  wire logic [DATA_W-1:0] convData,
  // tuning converter inputs
  output logic [DATA_W-1:0]      tuneLevelA,
  output logic [DATA_W-1:0]      tuneLevelB,
  // transmitter settings
  output logic [3:0]             modulation_depth_sel,
  output logic [6:0]             modDepthPercent,
  output logic [3:0]             rf_output_driver,
  output logic [12:0]            driverResHundredths,
  output logic                   driverHighZ
);

  // modulation depth in percent for each code
  function automatic logic [6:0] depthPercent(input logic [3:0] code);
    logic [6:0] pct;
    pct = 7'h00;
    case (code)
      4'h0:    pct = 7'd0;
      4'h1:    pct = 7'd8;
      4'h2:    pct = 7'd10;
      4'h3:    pct = 7'd11;
      4'h4:    pct = 7'd12;
      4'h5:    pct = 7'd13;
      4'h6:    pct = 7'd14;
      4'h7:    pct = 7'd15;
      4'h8:    pct = 7'd20;
      4'h9:    pct = 7'd25;
      4'hA:    pct = 7'd30;
      4'hB:    pct = 7'd40;
      4'hC:    pct = 7'd50;
      4'hD:    pct = 7'd60;
      4'hE:    pct = 7'd70;
      default: pct = 7'd82;
    endcase
    return pct;
  endfunction

  // normalized driver resistance in hundredths, zero when floating
  function automatic logic [12:0] resHundredths(input logic [3:0] code);
    logic [12:0] r;
    r = 13'h0000;
    case (code)
      4'h0:    r = 13'd100;
      4'h1:    r = 13'd119;
      4'h2:    r = 13'd140;
      4'h3:    r = 13'd161;
      4'h4:    r = 13'd179;
      4'h5:    r = 13'd202;
      4'h6:    r = 13'd249;
      4'h7:    r = 13'd294;
      4'h8:    r = 13'd341;
      4'h9:    r = 13'd406;
      4'hA:    r = 13'd595;
      4'hB:    r = 13'd826;
      4'hC:    r = 13'd1710;
      4'hD:    r = 13'd3660;
      4'hE:    r = 13'd5120;
      default: r = 13'd0;
    endcase
    return r;
  endfunction

  // register index from a byte address
  function automatic logic [ADDR_W-3:0] regIndex(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // write channel holding state
  logic              awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic              wHeld_q;
  logic [7:0]        wByte_q;
  logic              wLane0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  // read channel state
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  // settings
  logic [DATA_W-1:0] tuneA_q;
  logic [DATA_W-1:0] tuneB_q;
  logic [3:0]        modSel_q;
  logic [3:0]        resSel_q;
  // decoded driver values, registered together with their codes
  logic [6:0]        modPct_q;
  logic [12:0]       resHund_q;
  logic              highZ_q;
  // held converter result
  logic [DATA_W-1:0] convResult;

  nfs_result_latch #(
    .WIDTH (DATA_W)
  ) u_result (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .convDone (convDone),
    .convData (convData),
    .result   (convResult)
  );

  // handshake decode
  wire awTake  = s_axi_awvalid & s_axi_awready;
  wire wTake   = s_axi_wvalid & s_axi_wready;
  wire arTake  = s_axi_arvalid & s_axi_arready;
  wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;

  // write address decode
  wire [ADDR_W-3:0] wIdx   = regIndex(awAddr_q);
  wire              wStat  = (wIdx == (ADDR_W-2)'(nfs_pkg::IDX_STATUS));
  wire              wRes   = (wIdx == (ADDR_W-2)'(nfs_pkg::IDX_RESULT));
  wire              wTuneA = (wIdx == (ADDR_W-2)'(nfs_pkg::IDX_TUNE_A));
  wire              wTuneB = (wIdx == (ADDR_W-2)'(nfs_pkg::IDX_TUNE_B));
  wire              wDrv   = (wIdx == (ADDR_W-2)'(nfs_pkg::IDX_DRIVER));
  wire              wHit   = wStat | wRes | wTuneA | wTuneB | wDrv;
  wire              wEn    = doWrite & wLane0_q;

  // read address decode
  wire [ADDR_W-3:0] rIdx   = regIndex(s_axi_araddr);
  wire              rStat  = (rIdx == (ADDR_W-2)'(nfs_pkg::IDX_STATUS));
  wire              rRes   = (rIdx == (ADDR_W-2)'(nfs_pkg::IDX_RESULT));
  wire              rTuneA = (rIdx == (ADDR_W-2)'(nfs_pkg::IDX_TUNE_A));
  wire              rTuneB = (rIdx == (ADDR_W-2)'(nfs_pkg::IDX_TUNE_B));
  wire              rDrv   = (rIdx == (ADDR_W-2)'(nfs_pkg::IDX_DRIVER));
  wire              rHit   = rStat | rRes | rTuneA | rTuneB | rDrv;

  // status word; bits 7:6 read as zero
  logic [7:0] statusWord;
  always_comb begin
    statusWord = 8'h00;
    statusWord[nfs_pkg::RATE_LSB +: 2]  = detectedRate;
    statusWord[nfs_pkg::GUARD2_BIT]     = second_guard_timer_running;
    statusWord[nfs_pkg::GPT_BIT]        = gpTimerRunning;
    statusWord[nfs_pkg::NORESP_BIT]     = noRespTimerRunning;
    statusWord[nfs_pkg::MASKRX_BIT]     = maskRxTimerRunning;
  end

  wire [7:0] driverWord = {modSel_q, resSel_q};

  // driver fields as they will be stored
  wire [3:0] modNext = wByte_q[nfs_pkg::MOD_LSB +: 4];
  wire [3:0] resNext = wByte_q[nfs_pkg::RES_LSB +: 4];

  wire [31:0] readMux =
    rStat  ? {24'h000000, statusWord} :
    rRes   ? {{(32-DATA_W){1'b0}}, convResult} :
    rTuneA ? {{(32-DATA_W){1'b0}}, tuneA_q} :
    rTuneB ? {{(32-DATA_W){1'b0}}, tuneB_q} :
    rDrv   ? {24'h000000, driverWord} :
             32'h00000000;

  // write channel: address and data in either order
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else if (awTake) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wHeld_q  <= 1'b0;
      wByte_q  <= 8'h00;
      wLane0_q <= 1'b0;
    end else if (wTake) begin
      wHeld_q  <= 1'b1;
      wByte_q  <= s_axi_wdata[7:0];
      wLane0_q <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_q  <= 1'b0;
    end
  end

  // response follows both halves
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= nfs_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wHit ? nfs_pkg::RESP_OKAY : nfs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read-write settings; status and result have no write path
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tuneA_q <= DATA_W'(nfs_pkg::TUNE_RST);
    end else if (wEn && wTuneA) begin
      tuneA_q <= DATA_W'(wByte_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tuneB_q <= DATA_W'(nfs_pkg::TUNE_RST);
    end else if (wEn && wTuneB) begin
      tuneB_q <= DATA_W'(wByte_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      modSel_q  <= nfs_pkg::MOD_RST;
      resSel_q  <= nfs_pkg::RES_RST;
      modPct_q  <= depthPercent(nfs_pkg::MOD_RST);
      resHund_q <= resHundredths(nfs_pkg::RES_RST);
      highZ_q   <= (nfs_pkg::RES_RST == nfs_pkg::RES_HIGHZ);
    end else if (wEn && wDrv) begin
      modSel_q  <= modNext;
      resSel_q  <= resNext;
      modPct_q  <= depthPercent(modNext);
      resHund_q <= resHundredths(resNext);
      highZ_q   <= (resNext == nfs_pkg::RES_HIGHZ);
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= nfs_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid_q <= 1'b1;
      rdata_q  <= readMux;
      rresp_q  <= rHit ? nfs_pkg::RESP_OKAY : nfs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // bus outputs
  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready  = ~wHeld_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // setting outputs
  assign tuneLevelA           = tuneA_q;
  assign tuneLevelB           = tuneB_q;
  assign modulation_depth_sel = modSel_q;
  assign modDepthPercent      = modPct_q;
  assign rf_output_driver     = resSel_q;
  assign driverResHundredths  = resHund_q;
  assign driverHighZ          = highZ_q;

endmodule
`default_nettype wire

//--- verification/nfs_regs_monitor.sv
// nfs_regs_monitor: field and response checks on the register bank
// assumes writes offer address and data together, bound to nfs_regs
`timescale 1ns/1ps
`default_nettype none
module nfs_regs_monitor #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  // status
  input wire logic [1:0]        detectedRate,
  input wire logic              second_guard_timer_running,
  input wire logic              gpTimerRunning,
  input wire logic              noRespTimerRunning,
  input wire logic              maskRxTimerRunning,
  // settings
  input wire logic [DATA_W-1:0] tuneLevelA,
  input wire logic [DATA_W-1:0] tuneLevelB,
  input wire logic [3:0]        modulation_depth_sel,
  input wire logic [6:0]        modDepthPercent,
  input wire logic [3:0]        rf_output_driver,
  input wire logic              driverHighZ
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence wr_to(logic [11:0] a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr == a && s_axi_wstrb[0];
  endsequence
  sequence rd_st;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h090;
  endsequence
  AST_RATE: assert property (rd_st |=> s_axi_rdata[7:4] == {2'h0, $past(detectedRate)})
    else $error("status rate field wrong");
  AST_TIMERS: assert property (rd_st |=> s_axi_rdata[3:0] ==
    $past({second_guard_timer_running, gpTimerRunning, noRespTimerRunning, maskRxTimerRunning}))
    else $error("status timer bits wrong");
  AST_TUNE_A: assert property (wr_to(12'h098) |=> ##1 tuneLevelA == $past(s_axi_wdata[7:0], 2))
    else $error("first tuning level not written");
  AST_TUNE_B: assert property (wr_to(12'h09C) |=> ##1 tuneLevelB == $past(s_axi_wdata[7:0], 2))
    else $error("second tuning level not written");
  AST_RESET: assert property ($rose(reset_n) |-> tuneLevelA == 8'h80 &&
    tuneLevelB == 8'h80 && modulation_depth_sel == 4'h7 && modDepthPercent == 7'h0F &&
    rf_output_driver == 4'h0) else $error("reset values wrong");
  AST_MOD: assert property (modulation_depth_sel == 4'hF |-> modDepthPercent == 7'h52)
    else $error("top modulation depth wrong");
  AST_HIGHZ: assert property (driverHighZ == (rf_output_driver == 4'hF))
    else $error("high impedance flag wrong");
  AST_RO_WRITE: assert property ((wr_to(12'h090) or wr_to(12'h094)) |=> ##1
    s_axi_bvalid && s_axi_bresp == 2'h0 &&
    $stable({tuneLevelA, tuneLevelB, modulation_depth_sel, rf_output_driver}))
    else $error("read-only write disturbed state");
endmodule
bind nfs_regs nfs_regs_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) nfs_regs_monitor_inst (
  .ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .detectedRate, .second_guard_timer_running,
  .gpTimerRunning, .noRespTimerRunning, .maskRxTimerRunning, .tuneLevelA, .tuneLevelB,
  .modulation_depth_sel, .modDepthPercent, .rf_output_driver, .driverHighZ);
`default_nettype wire

//--- verification/nfs_fe_model.sv
// nfs_fe_model: stands in for the receiver, timers and converter
// assumes its tasks are called right after a rising ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module nfs_fe_model (
  // clock
  input  wire logic      ref_clk,
  // status
  output var logic [1:0] detectedRate,
  output var logic       second_guard_timer_running,
  output var logic       gpTimerRunning,
  output var logic       noRespTimerRunning,
  output var logic       maskRxTimerRunning,
  // converter
  output var logic       convDone,
  output var logic [7:0] convData
);
  initial begin
    detectedRate = 2'h0;
    {second_guard_timer_running, gpTimerRunning, noRespTimerRunning, maskRxTimerRunning} = 4'h0;
    convDone = 1'h0;
    convData = 8'h00;
  end
  task automatic set_status(input logic [1:0] r, input logic [3:0] t);
    detectedRate <= r;
    {second_guard_timer_running, gpTimerRunning, noRespTimerRunning, maskRxTimerRunning} <= t;
  endtask
  task automatic convert(input logic [7:0] d);
    convDone <= 1'h1;
    convData <= d;
    @(posedge ref_clk);
    convDone <= 1'h0;
    // data invalid once the pulse ends
    convData <= ~d;
  endtask
endmodule
`default_nettype wire

//--- verification/nfs_regs_bench.sv
// nfs_regs_bench: drives the register bank over the bus
// assumes nfs_fe_model feeds the status and converter inputs
`timescale 1ns/1ps
`default_nettype none
module nfs_regs_bench;
  logic        ref_clk = 1'h0, reset_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, dat;
  logic [3:0]  s_axi_wstrb = 4'hF, modulation_depth_sel, rf_output_driver;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, detectedRate, rsp;
  logic        second_guard_timer_running, gpTimerRunning, noRespTimerRunning;
  logic        maskRxTimerRunning, convDone, driverHighZ;
  logic [7:0]  convData, tuneLevelA, tuneLevelB;
  logic [6:0]  modDepthPercent;
  logic [12:0] driverResHundredths;
  int          miscompares = 0, n_tests = 0;
  int pct [16] = '{0, 8, 10, 11, 12, 13, 14, 15, 20, 25, 30, 40, 50, 60, 70, 82};
  int res [16] = '{100, 119, 140, 161, 179, 202, 249, 294, 341, 406, 595, 826, 1710, 3660,
                   5120, 0};
  always #2.5 ref_clk = ~ref_clk;
  nfs_regs nfs_regs_inst (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .detectedRate, .second_guard_timer_running, .gpTimerRunning,
    .noRespTimerRunning, .maskRxTimerRunning, .convDone, .convData, .tuneLevelA, .tuneLevelB,
    .modulation_depth_sel, .modDepthPercent, .rf_output_driver, .driverResHundredths,
    .driverHighZ);
  nfs_fe_model nfs_fe_model_inst (.ref_clk, .detectedRate, .second_guard_timer_running,
    .gpTimerRunning, .noRespTimerRunning, .maskRxTimerRunning, .convDone, .convData);
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    int   n;
    {aw, w, r} = 4'hF;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    if (n == 20) begin
      miscompares++;
      stop_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (s_axi_rvalid) begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
        break;
      end
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    if (n == 20) begin
      miscompares++;
      stop_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic t_reset();
    logic [7:0] ix [5] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
    logic [7:0] ex [5] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h70};
    chk(32'({tuneLevelA, tuneLevelB, modulation_depth_sel, rf_output_driver}), 32'h808070);
    for (int i = 0; i < 5; i++) begin
      rd(ad(ix[i]), dat, rsp);
      chk(dat, 32'(ex[i]));
    end
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      nfs_fe_model_inst.set_status(2'(i), 4'(1 << i));
      rd(ad(nfs_pkg::IDX_STATUS), dat, rsp);
      chk(dat, 32'((i << 4) | (1 << i)));
    end
    wr(ad(nfs_pkg::IDX_STATUS), 8'h00, rsp);
    chk(32'(rsp), 32'(nfs_pkg::RESP_OKAY));
    rd(ad(nfs_pkg::IDX_STATUS), dat, rsp);
    chk(dat, 32'h38);
  endtask
  task automatic t_result();
    nfs_fe_model_inst.convert(8'h5A);
    wr(ad(nfs_pkg::IDX_RESULT), 8'hC3, rsp);
    chk(32'(rsp), 32'(nfs_pkg::RESP_OKAY));
    rd(ad(nfs_pkg::IDX_RESULT), dat, rsp);
    chk(dat, 32'h5A);
    nfs_fe_model_inst.convert(8'hA5);
    rd(ad(nfs_pkg::IDX_RESULT), dat, rsp);
    chk(dat, 32'hA5);
  endtask
  task automatic t_tune();
    wr(ad(nfs_pkg::IDX_TUNE_A), 8'h3C, rsp);
    wr(ad(nfs_pkg::IDX_TUNE_B), 8'hC3, rsp);
    s_axi_wstrb <= 4'h0;
    wr(ad(nfs_pkg::IDX_TUNE_A), 8'h11, rsp);
    s_axi_wstrb <= 4'hF;
    chk(32'({tuneLevelA, tuneLevelB}), 32'h3CC3);
    rd(ad(nfs_pkg::IDX_TUNE_B), dat, rsp);
    chk(dat, 32'hC3);
  endtask
  task automatic t_driver();
    for (int c = 0; c < 16; c++) begin
      wr(ad(nfs_pkg::IDX_DRIVER), 8'((c << 4) | (15 - c)), rsp);
      rd(ad(nfs_pkg::IDX_DRIVER), dat, rsp);
      chk(dat, 32'((c << 4) | (15 - c)));
      chk(32'({modulation_depth_sel, modDepthPercent}), 32'((c << 7) | pct[c]));
      chk(32'({driverHighZ, driverResHundredths}), 32'({c == 0, 13'(res[15 - c])}));
    end
  endtask
  task automatic t_bad();
    wr(12'h0A4, 8'h11, rsp);
    chk(32'(rsp), 32'(nfs_pkg::RESP_SLVERR));
    rd(12'h0A4, dat, rsp);
    chk(dat, 32'h00000000);
    chk(32'(rsp), 32'(nfs_pkg::RESP_SLVERR));
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    t_reset();
    t_status();
    t_result();
    t_tune();
    t_driver();
    t_bad();
    stop_test();
  end
endmodule
`default_nettype wire
